/* verilog/dswp_port.sv */
// dswp_port.sv: serial write port of a single-channel dac
`timescale 1ns/100ps
`default_nettype none
`include "dswp_map.svh"
// ==========================================================
// serial write port top
// Functional notes
// RQ1: narrow variant applies the frame on falling edge sixteen.
// RQ2: narrow frame aborted early clears shifter, output unchanged.
// RQ3: wide variant shifts through a 24-bit register per frame.
// RQ4: wide frame: two power-down bits, sixteen code bits, six ignored.
// RQ5: write starts at frame select fall; bits sampled on falling clock.
// RQ6: wide variant updates after the eighteenth falling edge.
// RQ7: host raises frame select at least 20 ns between writes.
// RQ8: host may release frame select right after bit eighteen.
// RQ9: wide frame aborted early clears shifter, output unchanged.
// RQ10: host sends the most significant bit first.
// RQ11: byte hosts hold frame select low across all bytes.
// RQ12: spi hosts use clock polarity 0, phase 1.
// RQ13: narrow variant uses a 16-bit shifter, power bits first.
// RQ14: power code 00 normal, 01 1k, 10 100k, 11 high impedance.
// RQ15: reset loads zero code; power-down keeps the stored code.
// RQ16: narrow code is fourteen bits after the power bits.
// RQ17: edges after the update edge change nothing in the frame.
module dswp_port
    import dswp_pkg::*;
#(
    parameter bit WIDE = 1'b1
) (
    // clock, reset, enable
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // serial pins, sampled synchronously
    input wire logic frame_sel_n_in,
    input wire logic sclk_in,
    input wire logic sdata_in,
    // applied output state
    output logic [`DSWP_CODE_WIDTH-1:0] code_out,
    output logic [`DSWP_PD_WIDTH-1:0] pwrdn_out,
    output logic pd_1k_out,
    output logic pd_100k_out,
    output logic pd_hiz_out,
    output logic update_out,
    output logic abort_out,
    output logic busy_out
);
    // ==========================================================
    // frame geometry
    localparam int FRAME = WIDE ? `DSWP_FRAME_WIDE : `DSWP_FRAME_NARROW;
    localparam int UPD = WIDE ? `DSWP_UPDATE_WIDE : `DSWP_UPDATE_NARROW;

    dswp_state_e state;
    dswp_state_e next_state;
    logic [23:0] shifter;
    logic [4:0] nbits;
    logic sclk_d;
    logic sel_d;

    // build the applied word from the shifter once enough bits are in
    function automatic dswp_word_t frame_word(input logic [23:0] sh, input logic [4:0] n);
        dswp_word_t w;
        w = '0;
        if (WIDE) begin
            // RQ4 power bits then code bits
            w = {sh[17:16], sh[15:0]};
        end else begin
            // RQ16 fourteen code bits after power bits
            w = {sh[15:14], sh[13:0], 2'b00};
        end
        if (n == 5'd0) begin
            w = '0;
        end
        return w;
    endfunction : frame_word

    // ==========================================================
    // edge detection on the sampled pins
    wire sclk_fall = sclk_d && !sclk_in;
    wire sel_fall = sel_d && !frame_sel_n_in;
    wire sel_high = frame_sel_n_in;
    // the update edge is fall number UPD counted from frame open
    wire last_edge = sclk_fall && (nbits == 5'(UPD - 1));
    // frame select back high before the update edge
    wire frame_abort = (state == DSWP_SHIFT) && sel_high;
    wire fifo_ready;

    dswp_stream_if #(.WIDTH(18)) in_s ();
    dswp_stream_if #(.WIDTH(18)) out_s ();

    // previous pin levels
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            // idle pin levels, so no false clock fall follows reset
            sclk_d <= 1'b0;
            sel_d <= 1'b1;
        end else if (ce_in) begin
            sclk_d <= sclk_in;
            sel_d <= frame_sel_n_in;
        end
    end

    // ==========================================================
    // frame state machine
    always_comb begin
        next_state = state;
        case (state)
            DSWP_IDLE: begin
                // RQ5 falling frame select opens a write
                if (sel_fall) begin
                    next_state = DSWP_SHIFT;
                end
            end
            DSWP_SHIFT: begin
                // RQ2 RQ9 early rise aborts the frame
                if (sel_high) begin
                    next_state = DSWP_IDLE;
                end else if (last_edge && fifo_ready) begin
                    next_state = DSWP_DONE;
                end
            end
            DSWP_DONE: begin
                // RQ17 wait for frame select to rise
                if (sel_high) begin
                    next_state = DSWP_IDLE;
                end
            end
            default: next_state = DSWP_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= DSWP_IDLE;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // ==========================================================
    // shift register and bit count
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            shifter <= '0;
            nbits <= '0;
        end else if (ce_in) begin
            if (state != DSWP_SHIFT || sel_high) begin
                // RQ2 RQ9 cleared shifter on abort or idle
                shifter <= '0;
                nbits <= '0;
            end else if (sclk_fall && nbits < 5'(FRAME)) begin
                // RQ3 RQ13 msb first shift on falling clock
                shifter <= {shifter[22:0], sdata_in};
                nbits <= nbits + 5'd1;
            end
        end
    end

    // ==========================================================
    // word fifo between frame capture and output update
    // an update is only taken when the fifo has room; with a full fifo the word is dropped and the frame ends as an abort
    assign in_s.valid = (state == DSWP_SHIFT) && !sel_high && last_edge;
    // RQ1 RQ6 apply on the update edge
    assign in_s.data = frame_word({shifter[22:0], sdata_in}, 5'd1);
    assign fifo_ready = in_s.ready;
    assign out_s.ready = 1'b1;

    // drained every cycle, so a dropped word would need sixteen queued words
    dswp_fifo #(.WIDTH(18), .DEPTH(`DSWP_FIFO_DEPTH)) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .wr(in_s),
        .rd(out_s)
    );

    // ==========================================================
    // applied code and power mode
    // a word leaves the fifo the cycle after it lands
    wire take = out_s.valid && ce_in;
    wire [1:0] pd_next = out_s.data[17:16];
    // RQ15 power-down frames keep the stored code
    // only a normal-mode frame carries a code that reaches the output
    wire code_load = take && (pd_next == DSWP_PD_NORMAL);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            // RQ15 zero code at power up
            code_out <= `DSWP_CODE_RESET;
            pwrdn_out <= `DSWP_PD_RESET;
            pd_1k_out <= 1'b0;
            pd_100k_out <= 1'b0;
            pd_hiz_out <= 1'b0;
            update_out <= 1'b0;
        end else if (ce_in) begin
            update_out <= take;
            if (code_load) begin
                // RQ15 code register written by normal-mode frames only
                code_out <= out_s.data[15:0];
            end
            if (take) begin
                pwrdn_out <= pd_next;
                // RQ14 power-down decode
                pd_1k_out <= (pd_next == DSWP_PD_1K);
                pd_100k_out <= (pd_next == DSWP_PD_100K);
                pd_hiz_out <= (pd_next == DSWP_PD_HIZ);
            end
        end
    end

    // status flags
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            abort_out <= 1'b0;
            busy_out <= 1'b0;
        end else if (ce_in) begin
            abort_out <= frame_abort;
            busy_out <= (next_state == DSWP_SHIFT);
        end
    end

endmodule : dswp_port
`default_nettype wire

/* verilog/dswp_map.svh */
// dswp_map.svh: constants of the dac serial write port
`ifndef DSWP_MAP_SVH
`define DSWP_MAP_SVH
`define DSWP_FRAME_WIDE 24
`define DSWP_FRAME_NARROW 16
`define DSWP_UPDATE_WIDE 18
`define DSWP_UPDATE_NARROW 16
`define DSWP_CODE_WIDTH 16
`define DSWP_PD_WIDTH 2
`define DSWP_CODE_RESET 16'h0000
`define DSWP_PD_RESET 2'h0
`define DSWP_FIFO_DEPTH 16
`define DSWP_GAP_NS 20
`define DSWP_CLK_NS 25
`endif

/* verilog/dswp_pkg.sv */
// dswp_pkg.sv: types of the dac serial write port
package dswp_pkg;
    typedef enum logic [1:0] {
        DSWP_PD_NORMAL = 2'b00,
        DSWP_PD_1K = 2'b01,
        DSWP_PD_100K = 2'b10,
        DSWP_PD_HIZ = 2'b11
    } dswp_pd_e;
    typedef enum logic [1:0] {
        DSWP_IDLE = 2'b00,
        DSWP_SHIFT = 2'b01,
        DSWP_DONE = 2'b10
    } dswp_state_e;
    typedef logic [17:0] dswp_word_t;
endpackage : dswp_pkg

/* verilog/dswp_stream_if.sv */
// dswp_stream_if.sv: valid/ready word stream between port modules
`timescale 1ns/100ps
`default_nettype none
interface dswp_stream_if #(parameter int WIDTH = 18);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dswp_stream_if
`default_nettype wire

/* verilog/dswp_fifo.sv */
// dswp_fifo.sv: parameterised synchronous word fifo
`timescale 1ns/100ps
`default_nettype none
module dswp_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // clock and control
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // streams
    dswp_stream_if.snk wr,
    dswp_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire push;
    wire pop;
    // honest full and empty from the count
    assign wr.ready = (cnt != (AW+1)'(DEPTH));
    assign rd.valid = (cnt != '0);
    assign rd.data = mem[rp];
    assign push = wr.valid && wr.ready && ce_in;
    assign pop = rd.valid && rd.ready && ce_in;
    // storage, no reset needed on data
    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wp] <= wr.data;
        end
    end
    // pointers and count
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + AW'(1);
            end
            if (pop) begin
                rp <= rp + AW'(1);
            end
            if (push && !pop) begin
                cnt <= cnt + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt <= cnt - (AW+1)'(1);
            end
        end
    end
endmodule : dswp_fifo
`default_nettype wire

/* testbench/dswp_port_checker.sv */
// dswp_port_checker.sv: pin-level checks on the serial write port
`timescale 1ns/100ps
`default_nettype none
module dswp_port_checker #(
    parameter bit WIDE = 1'b1
) (
    // clock and control
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // serial pins
    input wire logic frame_sel_n_in,
    input wire logic sclk_in,
    input wire logic sdata_in,
    // applied state
    input wire logic [15:0] code_out,
    input wire logic [1:0] pwrdn_out,
    input wire logic pd_1k_out,
    input wire logic pd_100k_out,
    input wire logic pd_hiz_out,
    input wire logic update_out,
    input wire logic abort_out,
    input wire logic busy_out
);
    // ==========
    // checks
    localparam int UPD = WIDE ? 18 : 16;
    logic [4:0] falls;
    logic sclk_q;
    logic sel_q;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // falls since frame open; saturates so long frames stay legal
    always_ff @(posedge clock_in) begin
        sclk_q <= sclk_in;
        sel_q <= rst_in | frame_sel_n_in;
        if (rst_in || (sel_q && !frame_sel_n_in)) falls <= 5'h0;
        else if (ce_in && sclk_q && !sclk_in && falls != 5'h1f) falls <= falls + 5'h1;
    end
    sequence s_sel_idle;
        frame_sel_n_in [*8];
    endsequence
    sequence s_no_update;
        !update_out [*3];
    endsequence
    a_update_pulse: assert property (update_out |=> !update_out)
        else $error("long update");
    a_update_edge: assert property (update_out |-> falls inside {[UPD:UPD + 2]})
        else $error("update off edge");
    a_code_hold: assert property ($changed(code_out) |-> update_out)
        else $error("code moved");
    a_mode_hold: assert property ($changed(pwrdn_out) |-> update_out)
        else $error("mode moved");
    a_mode_decode: assert property (
        {pd_hiz_out, pd_100k_out, pd_1k_out}
        == {&pwrdn_out, pwrdn_out == 2'b10, pwrdn_out == 2'b01}) else $error("bad decode");
    a_code_pd_hold: assert property ($changed(code_out) |-> pwrdn_out == 2'b00)
        else $error("code moved in power-down");
    a_abort_quiet: assert property (abort_out |-> s_no_update)
        else $error("abort updated");
    a_abort_cause: assert property (abort_out |-> frame_sel_n_in || $past(frame_sel_n_in))
        else $error("stray abort");
    a_idle_quiet: assert property (s_sel_idle |-> !update_out && !busy_out)
        else $error("idle activity");
endmodule : dswp_port_checker
`default_nettype wire

/* testbench/dswp_host_model.sv */
// dswp_host_model.sv: behavioural host writing frames on the serial pins
`timescale 1ns/100ps
`default_nettype none
module dswp_host_model (
    // bench clock
    input wire logic clock_in,
    // serial pins
    output logic frame_sel_n_out,
    output logic sclk_out,
    output logic sdata_out
);
    // ==========
    // host
    initial begin
        frame_sel_n_out = 1'b1;
        sclk_out = 1'b0;
        sdata_out = 1'b0;
    end
    // idle data wanders so a stale bit never looks fresh
    always @(negedge clock_in) if (frame_sel_n_out) sdata_out <= ~sdata_out;
    task automatic send(input logic [23:0] w, input int n);
        int i;
        @(negedge clock_in);
        frame_sel_n_out = 1'b0;
        for (i = 0; i < n; i++) begin
            @(negedge clock_in);
            sclk_out = 1'b1;
            sdata_out = i < 24 ? w[23 - i] : 1'($urandom);
            repeat ($urandom % 2) @(negedge clock_in);
            @(negedge clock_in);
            sclk_out = 1'b0;
        end
        // release at once, then a gap
        @(negedge clock_in);
        frame_sel_n_out = 1'b1;
        repeat (2) @(negedge clock_in);
    endtask : send
endmodule : dswp_host_model
`default_nettype wire

/* testbench/dswp_port_tb_top.sv */
// dswp_port_tb_top.sv: bench for both frame widths on shared pins
`timescale 1ns/100ps
`default_nettype none
module dswp_port_tb_top;
    // ==========
    // bench
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic sel_n, sclk, sdata, upd_w, upd_n;
    logic [15:0] code_w, code_n;
    logic [1:0] pd_w, pd_n;
    logic [17:0] qw[$], qn[$];
    logic [17:0] ew;
    logic [15:0] lw = 16'h0, ln = 16'h0;
    logic ab_w;
    wire [2:0] dec_w;
    int n_errors = 0, num_checks = 0, k, n_ab = 0, exp_ab = 0;
    always #12.5 clock_in = ~clock_in;
    dswp_host_model u_host (.clock_in, .frame_sel_n_out(sel_n), .sclk_out(sclk),
        .sdata_out(sdata));
    dswp_port #(.WIDE(1'b1)) dut (.clock_in, .rst_in, .ce_in, .frame_sel_n_in(sel_n),
        .sclk_in(sclk), .sdata_in(sdata), .code_out(code_w), .pwrdn_out(pd_w),
        .pd_1k_out(dec_w[0]), .pd_100k_out(dec_w[1]), .pd_hiz_out(dec_w[2]),
        .update_out(upd_w), .abort_out(ab_w),
        .busy_out());
    dswp_port #(.WIDE(1'b0)) dut_narrow (.clock_in, .rst_in, .ce_in, .frame_sel_n_in(sel_n),
        .sclk_in(sclk), .sdata_in(sdata), .code_out(code_n), .pwrdn_out(pd_n),
        .pd_1k_out(), .pd_100k_out(), .pd_hiz_out(), .update_out(upd_n), .abort_out(),
        .busy_out());
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // model: only frames reaching the update edge are queued
    // power-down frames keep the last stored code; wide aborts are counted
    task automatic frame(input logic [23:0] w, input int n);
        if (n >= 18) begin
            if (w[23:22] == 2'b00) lw = w[21:6];
            qw.push_back({w[23:22], lw});
        end
        if (n >= 16) begin
            if (w[23:22] == 2'b00) ln = {w[21:8], 2'b00};
            qn.push_back({w[23:22], ln});
        end
        if (n < 18) exp_ab++;
        u_host.send(w, n);
    endtask : frame
    // compare each applied update with the model; an unexpected one is a mismatch
    always @(negedge clock_in) begin
        if (ab_w === 1'b1) n_ab++;
        if (upd_w === 1'b1 && qw.size() == 0) check(18'h1, 18'h0);
        else if (upd_w === 1'b1) begin
            ew = qw.pop_front();
            check({pd_w, code_w}, ew);
            check(18'(dec_w), 18'({&ew[17:16], ew[17:16] == 2'b10, ew[17:16] == 2'b01}));
        end
        if (upd_n === 1'b1 && qn.size() == 0) check(18'h1, 18'h0);
        else if (upd_n === 1'b1) check({pd_n, code_n}, qn.pop_front());
    end
    initial begin
        #2000000;
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h0dccd5d8));
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        check({pd_w, code_w}, 18'h0);
        for (k = 0; k < 4; k++) frame({k[1:0], 22'($urandom)}, 24);
        frame(24'hffffff, 18);
        frame(24'h5a5a5a, 17);
        frame(24'hc3c3c3, 15);
        frame(24'h123456, 30);
        for (k = 0; k < 24; k++) begin
            frame(24'($urandom), 1 + $urandom % 30);
            repeat (3) @(negedge clock_in);
            ce_in = 1'b0;
            repeat (2) @(negedge clock_in);
            ce_in = 1'b1;
        end
        repeat (6) @(negedge clock_in);
        rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        lw = 16'h0;
        ln = 16'h0;
        check({pd_n, code_n}, 18'h0);
        check({pd_w, code_w}, 18'h0);
        frame(24'h9abcde, 24);
        repeat (6) @(negedge clock_in);
        check(18'(qw.size() + qn.size()), 18'h0);
        check(18'(n_ab), 18'(exp_ab));
        wrap_up();
    end
endmodule : dswp_port_tb_top
bind dswp_port dswp_port_checker #(.WIDE(WIDE)) u_chk (.clock_in, .rst_in, .ce_in,
    .frame_sel_n_in, .sclk_in, .sdata_in, .code_out, .pwrdn_out, .pd_1k_out,
    .pd_100k_out, .pd_hiz_out, .update_out, .abort_out, .busy_out);
`default_nettype wire
